// [design/cpck_pkg.sv]
// constants, register map and types shared by the clock and power control block
package cpck_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_POWER_UNLOCK_FIRST  = 32'hFFFF0404;
  localparam logic [31:0] ADDR_POWER_MODE_CONTROL  = 32'hFFFF0408;
  localparam logic [31:0] ADDR_POWER_UNLOCK_SECOND = 32'hFFFF040C;
  localparam logic [31:0] ADDR_CLOCK_UNLOCK_FIRST  = 32'hFFFF0410;
  localparam logic [31:0] ADDR_CLOCK_SOURCE_CONFIG = 32'hFFFF0414;
  localparam logic [31:0] ADDR_CLOCK_UNLOCK_SECOND = 32'hFFFF0418;
  localparam logic [31:0] ADDR_IRQ_STATUS          = 32'hFFFF0420;
  localparam logic [31:0] ADDR_IRQ_MASK            = 32'hFFFF0424;
  localparam logic [31:0] ADDR_CLOCK_STATUS        = 32'hFFFF0428;

  // reset values and writable bits
  localparam logic [7:0]  CLOCK_SOURCE_CONFIG_RST  = 8'h21;
  localparam logic [7:0]  POWER_MODE_CONTROL_RST   = 8'h03;
  localparam logic [7:0]  CLOCK_SOURCE_CONFIG_MASK = 8'h23;
  localparam logic [7:0]  POWER_MODE_CONTROL_MASK  = 8'h77;

  // unlock key values
  localparam logic [15:0] KEY_CLOCK_FIRST  = 16'h00AA;
  localparam logic [15:0] KEY_CLOCK_SECOND = 16'h0055;
  localparam logic [15:0] KEY_POWER_FIRST  = 16'h0001;
  localparam logic [15:0] KEY_POWER_SECOND = 16'h00F4;

  // clock_source_config fields
  localparam int          OSC_SEL_BIT   = 5;
  localparam int          CLK_MODE_LSB  = 0;
  localparam int          CLK_MODE_W    = 2;
  localparam logic [1:0]  CLK_MODE_PLL  = 2'h1;
  localparam logic [1:0]  CLK_MODE_EXT  = 2'h3;

  // power_mode_control fields
  localparam int          DIV_LSB       = 0;
  localparam int          DIV_W         = 3;
  localparam int          PMODE_LSB     = 4;
  localparam int          PMODE_W       = 3;
  localparam logic [2:0]  PM_ACTIVE     = 3'h0;
  localparam logic [2:0]  PM_PAUSE      = 3'h1;
  localparam logic [2:0]  PM_NAP        = 3'h2;
  localparam logic [2:0]  PM_SLEEP      = 3'h3;
  localparam logic [2:0]  PM_STOP       = 3'h4;

  // interrupt status bits
  localparam int          IRQ_PLL_UNLOCK = 0;
  localparam int          IRQ_WAKE       = 1;
  localparam int          IRQ_KEY_FAIL   = 2;
  localparam int          IRQ_W          = 3;

  // frequencies
  localparam logic [10:0] PLL_MULT        = 11'h4FB;
  localparam int          REF_FREQ_HZ     = 32768;
  localparam int          PLL_FREQ_HZ     = REF_FREQ_HZ * 1275;
  localparam int          EXT_CLK_MAX_HZ  = PLL_FREQ_HZ;
  localparam int          CLK_FREQ_HZ     = 50000000;
  localparam int          CLK_PERIOD_NS   = 1000000000 / CLK_FREQ_HZ;

  // wake-up times
  localparam int          NAP_WAKE_BASE_NS = 24;
  localparam int          NAP_WAKE_MAX_NS  = 3060;
  localparam int          SLEEP_WAKE_NS    = 1580000;
  localparam int          STOP_WAKE_NS     = 1700000;
  localparam int          SLEEP_WAKE_CYC   = (SLEEP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          STOP_WAKE_CYC    = (STOP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WAKE_CNT_W       = 17;

  typedef enum logic [1:0] {KEY_IDLE, KEY_ARMED, KEY_HELD} cpck_key_t;
  typedef enum logic [2:0] {ST_ACTIVE, ST_PAUSE, ST_NAP, ST_SLEEP, ST_STOP, ST_WAKE} cpck_mode_t;

endpackage : cpck_pkg

// [design/cpck_divider.sv]
// power-of-two tick divider for the core clock
module cpck_divider #(
  parameter int DIV_W = 3
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // source and selection
  input  wire logic             src_tick,
  input  wire logic [DIV_W-1:0] div_sel,
  // divided tick
  output logic                  tick
);

  localparam int              CNT_W = (1 << DIV_W) - 1;
  localparam logic [CNT_W:0]  ONE   = {{CNT_W{1'b0}}, 1'b1};

  logic [CNT_W-1:0] cnt;
  logic [CNT_W:0]   span;
  logic [CNT_W-1:0] limit;

  assign span  = ONE << div_sel;
  assign limit = CNT_W'(span - ONE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (src_tick) begin
        if (cnt >= limit) begin
          cnt  <= '0;
          tick <= 1'b1;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end

endmodule : cpck_divider

// [design/cpck_top.sv]
// clock source selection, core divider, power modes and key-protected registers
// Notes on behaviour
// - PLL multiplies 32.768 kHz reference by 1275
// - core clock divided by power of two, reset 8
// - core clock driven on clock output pin
// - two registers: clock source and power control
// - clock source change applied on entering nap
// - PLL lock loss raises PLL interrupt
// - core halts on unlock, interrupt after relock (pll_irq only; irq output rises while still unlocked)
// - external clock needs pin mode 2
// - each mode powers its own domain set
// - wake latency depends on mode and divider
// - protected write needs key before and after
// - oscillator select bit five, internal when set
// - clocking mode 01 PLL, 11 external
// - key values AA/55 clock, 01/F4 power
// - power mode field bits 6:4 encoding
// - divider field bits 2:0, two to field
//
// Decided for this implementation: the AHB-Lite slave port.
module cpck_top #(
  parameter int SLEEP_WAKE_CYCLES = cpck_pkg::SLEEP_WAKE_CYC,
  parameter int STOP_WAKE_CYCLES  = cpck_pkg::STOP_WAKE_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // asynchronous pins
  input  wire logic        pll_locked_pin,
  input  wire logic        ext_clock_pin,
  input  wire logic [3:0]  ext_irq_pin,
  // same-clock inputs
  input  wire logic        wake_timer_irq,
  input  wire logic        periph_irq,
  input  wire logic        clock_out_select,
  input  wire logic        ext_clock_pin_mode2,
  // clock and power controls
  output logic             core_clk_en,
  output logic             periph_clk_en,
  output logic             pll_enable,
  output logic [10:0]      pll_multiplier,
  output logic             osc_internal,
  output logic             xtal_enable,
  output logic             wake_timer_enable,
  output logic             ext_irq_enable,
  output logic             ext_clock_select,
  // clock output pin
  output logic             clock_out,
  output logic             clock_out_oe,
  // interrupts
  output logic             pll_irq,
  output logic             irq
);

  localparam int W = cpck_pkg::WAKE_CNT_W;

  // synchronisers
  logic [5:0]  sync1;
  logic [5:0]  sync2;
  logic        ext_clk_prev;
  logic        locked_prev;
  logic        locked_s;
  logic        extclk_s;
  logic [3:0]  ext_irq_s;

  // bus
  logic        addr_take;
  logic        wr_pend;
  logic        rd_pend;
  logic [31:0] dp_addr;
  logic        wr_fire;
  logic [31:0] rd_value;

  // registers
  logic [7:0]  clk_cfg;
  logic [7:0]  applied_cfg;
  logic [7:0]  pwr_ctl;
  logic [7:0]  clk_hold;
  logic [7:0]  pwr_hold;
  logic [cpck_pkg::IRQ_W-1:0] status;
  logic [cpck_pkg::IRQ_W-1:0] mask;
  logic [cpck_pkg::IRQ_W-1:0] irq_set;
  logic [cpck_pkg::IRQ_W-1:0] irq_clr;

  // key sequencers
  cpck_pkg::cpck_key_t clk_key;
  cpck_pkg::cpck_key_t next_clk_key;
  cpck_pkg::cpck_key_t pwr_key;
  cpck_pkg::cpck_key_t next_pwr_key;
  logic        clk_commit;
  logic        clk_fail;
  logic        pwr_commit;
  logic        pwr_fail;

  // power modes
  cpck_pkg::cpck_mode_t state;
  logic [W-1:0] wake_cnt;
  logic        wake_req;
  logic [2:0]  new_mode;
  logic        core_run;
  logic        periph_run;
  logic        pll_run;
  logic        xtal_run;
  logic        ext_run;

  // clock path
  logic        ext_sel_now;
  logic        pll_in_use;
  logic        src_tick;
  logic        div_tick;
  logic        core_ok;
  logic        unlock_evt;

  function automatic logic [W-1:0] nap_wake_cycles(input logic [2:0] div);
    logic [W-1:0] ns;
    ns = W'(cpck_pkg::NAP_WAKE_BASE_NS) << div;
    return W'((ns + W'(cpck_pkg::CLK_PERIOD_NS - 1)) / W'(cpck_pkg::CLK_PERIOD_NS));
  endfunction : nap_wake_cycles

  // pin synchronisation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else if (ce) begin
      sync1 <= {pll_locked_pin, ext_clock_pin, ext_irq_pin};
      sync2 <= sync1;
    end
  end

  assign locked_s  = sync2[5];
  assign extclk_s  = sync2[4];
  assign ext_irq_s = sync2[3:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_clk_prev <= 1'b0;
      locked_prev  <= 1'b0;
    end else if (ce) begin
      ext_clk_prev <= extclk_s;
      locked_prev  <= locked_s;
    end
  end

  // ahb-lite slave: writes zero wait, reads one wait state
  assign addr_take = hsel & htrans[1] & hready;
  assign wr_fire   = wr_pend & ce;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      dp_addr   <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      wr_pend   <= addr_take & hwrite;
      rd_pend   <= addr_take & ~hwrite;
      hreadyout <= ~(addr_take & ~hwrite);
      if (addr_take) begin
        dp_addr <= haddr;
      end
    end
  end

  always_comb begin
    case (dp_addr)
      cpck_pkg::ADDR_CLOCK_SOURCE_CONFIG: rd_value = {24'h000000, clk_cfg};
      cpck_pkg::ADDR_POWER_MODE_CONTROL:  rd_value = {24'h000000, pwr_ctl};
      cpck_pkg::ADDR_IRQ_STATUS:          rd_value = {29'h00000000, status};
      cpck_pkg::ADDR_IRQ_MASK:            rd_value = {29'h00000000, mask};
      cpck_pkg::ADDR_CLOCK_STATUS:        rd_value = {20'h00000, locked_s, 3'(state), applied_cfg};
      default:                            rd_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (ce && rd_pend) begin
      hrdata <= rd_value;
    end
  end

  // clock key sequence
  always_comb begin
    next_clk_key = clk_key;
    clk_commit   = 1'b0;
    clk_fail     = 1'b0;
    if (wr_fire) begin
      if (dp_addr == cpck_pkg::ADDR_CLOCK_UNLOCK_FIRST && hwdata[15:0] == cpck_pkg::KEY_CLOCK_FIRST) begin
        next_clk_key = cpck_pkg::KEY_ARMED;
      end else begin
        case (clk_key)
          cpck_pkg::KEY_ARMED: begin
            if (dp_addr == cpck_pkg::ADDR_CLOCK_SOURCE_CONFIG) begin
              next_clk_key = cpck_pkg::KEY_HELD;
            end else begin
              next_clk_key = cpck_pkg::KEY_IDLE;
              clk_fail     = 1'b1;
            end
          end
          cpck_pkg::KEY_HELD: begin
            next_clk_key = cpck_pkg::KEY_IDLE;
            if (dp_addr == cpck_pkg::ADDR_CLOCK_UNLOCK_SECOND && hwdata[15:0] == cpck_pkg::KEY_CLOCK_SECOND) begin
              clk_commit = 1'b1;
            end else begin
              clk_fail = 1'b1;
            end
          end
          default: next_clk_key = cpck_pkg::KEY_IDLE;
        endcase
      end
    end
  end

  // power key sequence
  always_comb begin
    next_pwr_key = pwr_key;
    pwr_commit   = 1'b0;
    pwr_fail     = 1'b0;
    if (wr_fire) begin
      if (dp_addr == cpck_pkg::ADDR_POWER_UNLOCK_FIRST && hwdata[15:0] == cpck_pkg::KEY_POWER_FIRST) begin
        next_pwr_key = cpck_pkg::KEY_ARMED;
      end else begin
        case (pwr_key)
          cpck_pkg::KEY_ARMED: begin
            if (dp_addr == cpck_pkg::ADDR_POWER_MODE_CONTROL) begin
              next_pwr_key = cpck_pkg::KEY_HELD;
            end else begin
              next_pwr_key = cpck_pkg::KEY_IDLE;
              pwr_fail     = 1'b1;
            end
          end
          cpck_pkg::KEY_HELD: begin
            next_pwr_key = cpck_pkg::KEY_IDLE;
            if (dp_addr == cpck_pkg::ADDR_POWER_UNLOCK_SECOND && hwdata[15:0] == cpck_pkg::KEY_POWER_SECOND) begin
              pwr_commit = 1'b1;
            end else begin
              pwr_fail = 1'b1;
            end
          end
          default: next_pwr_key = cpck_pkg::KEY_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_key  <= cpck_pkg::KEY_IDLE;
      pwr_key  <= cpck_pkg::KEY_IDLE;
      clk_hold <= 8'h00;
      pwr_hold <= 8'h00;
    end else if (ce) begin
      clk_key <= next_clk_key;
      pwr_key <= next_pwr_key;
      if (wr_fire && clk_key == cpck_pkg::KEY_ARMED && dp_addr == cpck_pkg::ADDR_CLOCK_SOURCE_CONFIG) begin
        clk_hold <= hwdata[7:0] & cpck_pkg::CLOCK_SOURCE_CONFIG_MASK;
      end
      if (wr_fire && pwr_key == cpck_pkg::KEY_ARMED && dp_addr == cpck_pkg::ADDR_POWER_MODE_CONTROL) begin
        pwr_hold <= hwdata[7:0] & cpck_pkg::POWER_MODE_CONTROL_MASK;
      end
    end
  end

  // clock source register: written value, applied value follows on nap entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_cfg     <= cpck_pkg::CLOCK_SOURCE_CONFIG_RST;
      applied_cfg <= cpck_pkg::CLOCK_SOURCE_CONFIG_RST;
    end else if (ce) begin
      if (clk_commit) begin
        clk_cfg <= clk_hold;
      end
      if (pwr_commit && pwr_hold[cpck_pkg::PMODE_LSB +: cpck_pkg::PMODE_W] == cpck_pkg::PM_NAP) begin
        applied_cfg <= clk_cfg;
      end
    end
  end

  // power control register; mode field returns to active on wake
  assign new_mode = pwr_hold[cpck_pkg::PMODE_LSB +: cpck_pkg::PMODE_W];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ctl <= cpck_pkg::POWER_MODE_CONTROL_RST;
    end else if (ce) begin
      if (pwr_commit) begin
        pwr_ctl <= pwr_hold;
      end else if (state == cpck_pkg::ST_WAKE && wake_cnt <= W'(1)) begin
        pwr_ctl[cpck_pkg::PMODE_LSB +: cpck_pkg::PMODE_W] <= cpck_pkg::PM_ACTIVE;
      end
    end
  end

  // wake sources per mode
  always_comb begin
    case (state)
      cpck_pkg::ST_PAUSE: wake_req = wake_timer_irq | periph_irq | (|ext_irq_s);
      cpck_pkg::ST_NAP:   wake_req = wake_timer_irq | (|ext_irq_s);
      cpck_pkg::ST_SLEEP: wake_req = wake_timer_irq | (|ext_irq_s);
      cpck_pkg::ST_STOP:  wake_req = |ext_irq_s;
      default:            wake_req = 1'b0;
    endcase
  end

  // operating mode state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= cpck_pkg::ST_ACTIVE;
      wake_cnt <= '0;
    end else if (ce) begin
      case (state)
        cpck_pkg::ST_ACTIVE: begin
          if (pwr_commit) begin
            case (new_mode)
              cpck_pkg::PM_PAUSE: state <= cpck_pkg::ST_PAUSE;
              cpck_pkg::PM_NAP:   state <= cpck_pkg::ST_NAP;
              cpck_pkg::PM_SLEEP: state <= cpck_pkg::ST_SLEEP;
              cpck_pkg::PM_STOP:  state <= cpck_pkg::ST_STOP;
              default:            state <= cpck_pkg::ST_ACTIVE;
            endcase
          end
        end
        cpck_pkg::ST_PAUSE, cpck_pkg::ST_NAP: begin
          if (wake_req) begin
            state    <= cpck_pkg::ST_WAKE;
            wake_cnt <= nap_wake_cycles(pwr_ctl[cpck_pkg::DIV_LSB +: cpck_pkg::DIV_W]);
          end
        end
        cpck_pkg::ST_SLEEP: begin
          if (wake_req) begin
            state    <= cpck_pkg::ST_WAKE;
            wake_cnt <= W'(SLEEP_WAKE_CYCLES);
          end
        end
        cpck_pkg::ST_STOP: begin
          if (wake_req) begin
            state    <= cpck_pkg::ST_WAKE;
            wake_cnt <= W'(STOP_WAKE_CYCLES);
          end
        end
        cpck_pkg::ST_WAKE: begin
          if (wake_cnt <= W'(1)) begin
            state    <= cpck_pkg::ST_ACTIVE;
            wake_cnt <= '0;
          end else begin
            wake_cnt <= wake_cnt - W'(1);
          end
        end
        default: state <= cpck_pkg::ST_ACTIVE;
      endcase
    end
  end

  // domains powered in each mode
  always_comb begin
    core_run   = 1'b0;
    periph_run = 1'b1;
    pll_run    = 1'b1;
    xtal_run   = 1'b1;
    ext_run    = 1'b1;
    case (state)
      cpck_pkg::ST_ACTIVE: core_run = 1'b1;
      cpck_pkg::ST_PAUSE:  core_run = 1'b0;
      cpck_pkg::ST_NAP:    periph_run = 1'b0;
      cpck_pkg::ST_SLEEP: begin
        periph_run = 1'b0;
        pll_run    = 1'b0;
      end
      cpck_pkg::ST_STOP: begin
        periph_run = 1'b0;
        pll_run    = 1'b0;
        xtal_run   = 1'b0;
      end
      default: core_run = 1'b0;
    endcase
  end

  // clock path
  assign ext_sel_now = (applied_cfg[cpck_pkg::CLK_MODE_LSB +: cpck_pkg::CLK_MODE_W] == cpck_pkg::CLK_MODE_EXT)
                       & ext_clock_pin_mode2;
  assign pll_in_use  = ~ext_sel_now & pll_run;
  assign src_tick    = ext_sel_now ? (extclk_s & ~ext_clk_prev) : (pll_in_use & locked_s);
  assign core_ok     = core_run & (ext_sel_now | locked_s);
  assign unlock_evt  = pll_in_use & locked_prev & ~locked_s;

  cpck_divider #(
    .DIV_W    (cpck_pkg::DIV_W)
  ) u_divider (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .src_tick (src_tick),
    .div_sel  (pwr_ctl[cpck_pkg::DIV_LSB +: cpck_pkg::DIV_W]),
    .tick     (div_tick)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_clk_en  <= 1'b0;
      clock_out    <= 1'b0;
      clock_out_oe <= 1'b0;
    end else if (ce) begin
      core_clk_en  <= div_tick & core_ok;
      clock_out_oe <= clock_out_select;
      if (div_tick && core_ok) begin
        clock_out <= ~clock_out;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_clk_en     <= 1'b0;
      pll_enable        <= 1'b0;
      pll_multiplier    <= cpck_pkg::PLL_MULT;
      osc_internal      <= 1'b1;
      xtal_enable       <= 1'b0;
      wake_timer_enable <= 1'b0;
      ext_irq_enable    <= 1'b0;
      ext_clock_select  <= 1'b0;
    end else if (ce) begin
      periph_clk_en     <= periph_run;
      pll_enable        <= pll_in_use;
      pll_multiplier    <= cpck_pkg::PLL_MULT;
      osc_internal      <= applied_cfg[cpck_pkg::OSC_SEL_BIT];
      xtal_enable       <= xtal_run & ~applied_cfg[cpck_pkg::OSC_SEL_BIT];
      wake_timer_enable <= xtal_run;
      ext_irq_enable    <= ext_run;
      ext_clock_select  <= ext_sel_now;
    end
  end

  // interrupt status, mask and outputs; a set wins over a clear
  always_comb begin
    irq_set = '0;
    irq_set[cpck_pkg::IRQ_PLL_UNLOCK] = unlock_evt;
    irq_set[cpck_pkg::IRQ_WAKE]       = (state == cpck_pkg::ST_WAKE) && (wake_cnt <= W'(1));
    irq_set[cpck_pkg::IRQ_KEY_FAIL]   = clk_fail | pwr_fail;
    irq_clr = '0;
    if (wr_fire && dp_addr == cpck_pkg::ADDR_IRQ_STATUS) begin
      irq_clr = hwdata[cpck_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status  <= '0;
      mask    <= '0;
      irq     <= 1'b0;
      pll_irq <= 1'b0;
    end else if (ce) begin
      status <= (status & ~irq_clr) | irq_set;
      if (wr_fire && dp_addr == cpck_pkg::ADDR_IRQ_MASK) begin
        mask <= hwdata[cpck_pkg::IRQ_W-1:0];
      end
      irq     <= |(status & mask);
      pll_irq <= status[cpck_pkg::IRQ_PLL_UNLOCK] & mask[cpck_pkg::IRQ_PLL_UNLOCK] & locked_s;
    end
  end

endmodule : cpck_top

// [verification/cpck_top_monitor.sv]
// assertions on the clock and power control ports
module cpck_top_monitor (
  // clock, reset and bus
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // clock and power
  input wire logic        pll_locked_pin,
  input wire logic        core_clk_en,
  input wire logic        periph_clk_en,
  input wire logic        pll_enable,
  input wire logic [10:0] pll_multiplier,
  input wire logic        pll_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire take = hsel && htrans[1] && hready && ce;
  chk_bus_okay: assert property (!hresp)
    else $error("bus response not okay");
  chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  chk_pll_ratio: assert property (pll_multiplier == 11'h4FB)
    else $error("pll ratio wrong");
  chk_unlock_halt: assert property ($fell(pll_locked_pin) |-> ##4 !core_clk_en [*4])
    else $error("core ran without lock");
  chk_irq_after_lock: assert property (!pll_locked_pin [*4] |-> !pll_irq)
    else $error("pll irq while unlocked");
  chk_idle_core: assert property (!periph_clk_en [*2] |-> !core_clk_en)
    else $error("core ran in low power");
  chk_pll_domains: assert property (!pll_enable |-> !periph_clk_en)
    else $error("peripherals on without pll");
  cover property (take && !hwrite);
  cover property ($fell(pll_locked_pin));
  cover property (!pll_enable);
endmodule : cpck_top_monitor

bind cpck_top cpck_top_monitor u_mon (.clk, .rst_n, .ce, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .pll_locked_pin, .core_clk_en, .periph_clk_en, .pll_enable, .pll_multiplier, .pll_irq);

// [verification/tb_top.sv]
// self-checking testbench for the clock and power control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        pll_locked_pin = 1'b1;
  logic [3:0]  ext_irq_pin = 4'h0;
  logic        wake_timer_irq = 1'b0;
  logic        clock_out_select = 1'b1, ce = 1'b1, periph_irq = 1'b0;
  logic        hreadyout, hresp, core_clk_en, periph_clk_en, pll_enable, osc_internal, xtal_enable, co;
  logic        wake_timer_enable, ext_irq_enable, ext_clock_select, clock_out, clock_out_oe, pll_irq, irq;
  logic [31:0] hrdata;
  logic [10:0] pll_multiplier;
  int          fail_count, checks_done, cyc, n, t;

  cpck_top #(.SLEEP_WAKE_CYCLES(20), .STOP_WAKE_CYCLES(20)) DUT (
    .clk, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .pll_locked_pin, .ext_clock_pin(1'b0), .ext_irq_pin, .wake_timer_irq,
    .periph_irq, .clock_out_select, .ext_clock_pin_mode2(1'b0), .core_clk_en, .periph_clk_en,
    .pll_enable, .pll_multiplier, .osc_internal, .xtal_enable, .wake_timer_enable, .ext_irq_enable,
    .ext_clock_select, .clock_out, .clock_out_oe, .pll_irq, .irq
  );

  initial forever #10 clk = ~clk;

  task automatic conclude;
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // cuts a hung run short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] v);
    checks_done++;
    if (v !== e) begin
      $display("[ERR] %s expected %h seen %h", s, e, v);
      fail_count++;
    end
  endtask : cmp

  task automatic cmpb(input string s, input logic e, input logic v);
    cmp(s, {31'h0, e}, {31'h0, v});
  endtask : cmpb

  // one single word transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string s);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    cmp(s, e, r);
  endtask : rd

  // first key sits one word below the protected register, second key one word above
  task automatic keyed(input logic [31:0] a, input logic [7:0] v);
    logic p;
    p = (a == cpck_pkg::ADDR_POWER_MODE_CONTROL);
    wr(a - 32'h4, p ? 32'h1 : 32'hAA);
    wr(a, {24'h0, v});
    wr(a + 32'h4, p ? 32'hF4 : 32'h55);
  endtask : keyed

  task automatic pulse(input logic [2:0] s);
    {periph_irq, ext_irq_pin[0], wake_timer_irq} <= s;
    repeat (40) @(posedge clk);
    {periph_irq, ext_irq_pin[0], wake_timer_irq} <= 3'h0;
    @(posedge clk);
  endtask : pulse

  // enter a low power mode, check its domains, then try the timer wake source, then the pin (or peripheral when per is set) wake source
  task automatic mode(input logic [7:0] v, input logic per, input logic pll, input logic tmr);
    keyed(cpck_pkg::ADDR_POWER_MODE_CONTROL, v);
    repeat (2) @(posedge clk);
    cmpb("periph_clk_en", per, periph_clk_en);
    cmpb("pll_enable", pll, pll_enable);
    cmpb("wake_timer_enable", tmr, wake_timer_enable);
    cmpb("ext_irq_enable", 1'b1, ext_irq_enable);
    pulse(3'h1);
    rd(cpck_pkg::ADDR_POWER_MODE_CONTROL, tmr ? 32'h03 : {24'h0, v}, "timer wake");
    keyed(cpck_pkg::ADDR_POWER_MODE_CONTROL, v);
    pulse({per, !per, 1'b0});
    rd(cpck_pkg::ADDR_POWER_MODE_CONTROL, 32'h03, "pin wake");
  endtask : mode

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(cpck_pkg::ADDR_CLOCK_SOURCE_CONFIG, 32'h21, "clock_source_config");
    rd(cpck_pkg::ADDR_POWER_MODE_CONTROL, 32'h03, "power_mode_control");
    rd(cpck_pkg::ADDR_CLOCK_UNLOCK_FIRST, 32'h0, "clock_unlock_first");
    rd(32'hFFFF0430, 32'h0, "unmapped");
    cmp("pll_multiplier", 32'h4FB, {21'h0, pll_multiplier});
    cmpb("clock_out_oe", 1'b1, clock_out_oe);
    ce <= 1'b0;
    wr(cpck_pkg::ADDR_IRQ_MASK, 32'h7);
    ce <= 1'b1;
    rd(cpck_pkg::ADDR_IRQ_MASK, 32'h0, "frozen write");
    for (int d = 0; d < 8; d++) begin
      keyed(cpck_pkg::ADDR_POWER_MODE_CONTROL, 8'(d));
      repeat (200) @(posedge clk);
      n = 0;
      t = 0;
      co = clock_out;
      repeat (128) begin
        @(posedge clk);
        n += core_clk_en;
        t += (clock_out != co);
        co = clock_out;
      end
      cmp("core ticks", 32'(128 >> d), 32'(n));
      cmp("clock_out edges", 32'(128 >> d), 32'(t));
    end
    keyed(cpck_pkg::ADDR_POWER_MODE_CONTROL, 8'h03);
    wr(cpck_pkg::ADDR_POWER_MODE_CONTROL, 32'h1);
    wr(cpck_pkg::ADDR_CLOCK_SOURCE_CONFIG, 32'h3);
    rd(cpck_pkg::ADDR_POWER_MODE_CONTROL, 32'h03, "unkeyed power");
    rd(cpck_pkg::ADDR_CLOCK_SOURCE_CONFIG, 32'h21, "unkeyed clock");
    wr(cpck_pkg::ADDR_IRQ_STATUS, 32'h7);
    wr(cpck_pkg::ADDR_POWER_UNLOCK_FIRST, 32'h1);
    wr(cpck_pkg::ADDR_POWER_MODE_CONTROL, 32'h2);
    wr(cpck_pkg::ADDR_POWER_UNLOCK_SECOND, 32'h55);
    rd(cpck_pkg::ADDR_POWER_MODE_CONTROL, 32'h03, "bad key");
    rd(cpck_pkg::ADDR_IRQ_STATUS, 32'h4, "key fail flag");
    cmpb("irq masked", 1'b0, irq);
    wr(cpck_pkg::ADDR_IRQ_MASK, 32'h4);
    repeat (2) @(posedge clk);
    cmpb("irq unmasked", 1'b1, irq);
    wr(cpck_pkg::ADDR_IRQ_STATUS, 32'h4);
    repeat (2) @(posedge clk);
    cmpb("irq cleared", 1'b0, irq);
    keyed(cpck_pkg::ADDR_CLOCK_SOURCE_CONFIG, 8'h01);
    rd(cpck_pkg::ADDR_CLOCK_SOURCE_CONFIG, 32'h01, "crystal request");
    cmpb("osc before nap", 1'b1, osc_internal);
    mode(8'h23, 1'b0, 1'b1, 1'b1);
    cmpb("osc after nap", 1'b0, osc_internal);
    cmpb("xtal_enable", 1'b1, xtal_enable);
    cmpb("ext_clock_select", 1'b0, ext_clock_select);
    mode(8'h13, 1'b1, 1'b1, 1'b1);
    mode(8'h33, 1'b0, 1'b0, 1'b1);
    mode(8'h43, 1'b0, 1'b0, 1'b0);
    wr(cpck_pkg::ADDR_IRQ_MASK, 32'h1);
    pll_locked_pin <= 1'b0;
    repeat (20) @(posedge clk);
    cmpb("pll_irq unlocked", 1'b0, pll_irq);
    pll_locked_pin <= 1'b1;
    repeat (6) @(posedge clk);
    cmpb("pll_irq relocked", 1'b1, pll_irq);
    rd(cpck_pkg::ADDR_IRQ_STATUS, 32'h3, "unlock and wake flags");
    conclude();
  end
endmodule : tb_top
